// ---- tast_map.svh ----
// register map, field positions and timing constants of the 16-bit timer
`ifndef TAST_MAP_SVH
`define TAST_MAP_SVH
//------------------------------------------------------------
// offsets
//------------------------------------------------------------
`define TAST_OFF_CTRL   4'h0
`define TAST_OFF_COUNT  4'h1
`define TAST_OFF_PERIOD 4'h2
`define TAST_OFF_STATUS 4'h3
`define TAST_OFF_SRC    4'h4
`define TAST_OP_WRITE   2'h0
`define TAST_OP_CLR     2'h1
`define TAST_OP_SET     2'h2
`define TAST_OP_INV     2'h3
//------------------------------------------------------------
// control fields
//------------------------------------------------------------
`define TAST_B_ON     15
`define TAST_B_IDLE   13
`define TAST_B_WBLK   12
`define TAST_B_WPEND  11
`define TAST_B_GATE   7
`define TAST_B_PS_HI  5
`define TAST_B_PS_LO  4
`define TAST_B_SYNC   2
`define TAST_B_CS     1
`define TAST_B_SOSC   0
`define TAST_B_FLAG   0
//------------------------------------------------------------
// values
//------------------------------------------------------------
`define TAST_PERIOD_RST 16'hFFFF
`define TAST_DIV1   8'h00
`define TAST_DIV8   8'h07
`define TAST_DIV64  8'h3F
`define TAST_DIV256 8'hFF
`define TAST_CLK_NS  10
`define TAST_XFER_NS 30
`define TAST_XFER_CYC ((`TAST_XFER_NS + `TAST_CLK_NS - 1) / `TAST_CLK_NS)
`endif

// ---- tast_pkg.sv ----
// types of the 16-bit timer
package tast_pkg;
    typedef enum logic [0:0] {
        TAST_W_IDLE = 1'b0,
        TAST_W_PEND = 1'b1
    } tast_wstate_type;

    typedef struct packed {
        logic            on;
        logic            idle_stop;
        logic            wr_block;
        logic            gate_en;
        logic [1:0]      prescale;
        logic            sync;
        logic            csrc;
        logic            sosc_sel;
        logic [15:0]     count;
        logic [15:0]     period;
        logic            match_flag;
        logic            match_pulse;
        logic [7:0]      pre_cnt;
        tast_wstate_type wstate;
        logic [3:0]      pend_cnt;
        logic [15:0]     staged;
        logic            ext_s1;
        logic            ext_s2;
        logic            ext_s3;
        logic            osc_s1;
        logic            osc_s2;
        logic            osc_s3;
        logic            gate_s1;
        logic            gate_s2;
        logic [31:0]     rdata;
    } tast_state_type;
endpackage

// ---- tast_timer.sv ----
// 16-bit timer with prescaler, gating and async count write
//
// The plain strobed port and the register addresses were decided locally.
`timescale 1ns/1ns
`include "tast_map.svh"
module tast_timer #(
    parameter logic [3:0] XFER_CYC = 4'(`TAST_XFER_CYC)
) (
    // clock and reset
    input  wire logic        mclk,
    input  wire logic        rst,
    // register port
    input  wire logic [7:0]  addr,
    input  wire logic [31:0] wdata,
    input  wire logic        wr,
    input  wire logic        rd,
    output logic [31:0]      rdata,
    // power state
    input  wire logic        idle_mode,
    input  wire logic        sleep_mode,
    // pins
    input  wire logic        external_count_input,
    input  wire logic        gate_input,
    input  wire logic        low_power_osc,
    // status
    output logic [15:0]      count_value,
    output logic             period_match,
    output logic             async_write_pending
);
    //------------------------------------------------------------
    // state
    //------------------------------------------------------------
    tast_pkg::tast_state_type q;
    tast_pkg::tast_state_type d;

    logic [3:0]  reg_sel;
    logic [1:0]  op;
    logic        alias_ok;
    logic        ctrl_wr;
    logic        cnt_wr;
    logic        per_wr;
    logic        stat_wr;
    logic        src_wr;
    logic        async_mode;
    logic        ext_lvl;
    logic        ext_prev;
    logic        ext_edge;
    logic        cnt_in;
    logic        run;
    logic [7:0]  div;
    logic        tick;
    logic        wrap;
    logic        cnt_accept;
    logic        cnt_direct;
    logic        cnt_commit;
    logic [31:0] ctrl_rd;
    logic [31:0] ctrl_new;
    logic [31:0] cnt_new;
    logic [31:0] per_new;
    logic [31:0] stat_new;
    logic [31:0] src_new;

    function automatic logic [31:0] tast_alias(
        input logic [31:0] old,
        input logic [31:0] wd,
        input logic [1:0]  o
    );
        logic [31:0] r;
        r = wd;
        case (o)
            `TAST_OP_CLR: r = old & ~wd;
            `TAST_OP_SET: r = old | wd;
            `TAST_OP_INV: r = old ^ wd;
            default:      r = wd;
        endcase
        return r;
    endfunction

    //------------------------------------------------------------
    // decode
    //------------------------------------------------------------
    always_comb begin
        reg_sel  = addr[7:4];
        op       = addr[3:2];
        alias_ok = (addr[1:0] == 2'h0);
        ctrl_wr  = 1'b0;
        cnt_wr   = 1'b0;
        per_wr   = 1'b0;
        stat_wr  = 1'b0;
        src_wr   = 1'b0;
        if (!wr || !alias_ok) begin
            ctrl_wr = 1'b0;
        end else if (reg_sel == `TAST_OFF_CTRL) begin
            ctrl_wr = 1'b1;
        end else if (reg_sel == `TAST_OFF_COUNT) begin
            cnt_wr = 1'b1;
        end else if (reg_sel == `TAST_OFF_PERIOD) begin
            per_wr = 1'b1;
        end else if (reg_sel == `TAST_OFF_STATUS) begin
            stat_wr = 1'b1;
        end else if (reg_sel == `TAST_OFF_SRC) begin
            src_wr = 1'b1;
        end
    end

    //------------------------------------------------------------
    // counting
    //------------------------------------------------------------
    always_comb begin
        async_mode = q.csrc & ~q.sync;
        ext_lvl    = q.sosc_sel ? q.osc_s2 : q.ext_s2;
        ext_prev   = q.sosc_sel ? q.osc_s3 : q.ext_s3;
        ext_edge   = ext_lvl & ~ext_prev;
        if (q.csrc) begin
            cnt_in = ext_edge;
        end else if (q.gate_en) begin
            cnt_in = q.gate_s2;
        end else begin
            cnt_in = 1'b1;
        end
        // bus clock stops in sleep, only the async path keeps going
        run = q.on & ~(idle_mode & q.idle_stop) & (~sleep_mode | async_mode);
        case (q.prescale)
            2'h0:    div = `TAST_DIV1;
            2'h1:    div = `TAST_DIV8;
            2'h2:    div = `TAST_DIV64;
            default: div = `TAST_DIV256;
        endcase
        tick = run & cnt_in & (q.pre_cnt == div);
        wrap = tick & (q.count == q.period);
        cnt_accept = cnt_wr & async_mode & ~(q.wstate == tast_pkg::TAST_W_PEND & q.wr_block);
        cnt_direct = cnt_wr & ~async_mode;
        cnt_commit = (q.wstate == tast_pkg::TAST_W_PEND) & (q.pend_cnt == 4'h1);
    end

    //------------------------------------------------------------
    // register images
    //------------------------------------------------------------
    always_comb begin
        ctrl_rd = 32'h0000_0000;
        ctrl_rd[`TAST_B_ON]    = q.on;
        ctrl_rd[`TAST_B_IDLE]  = q.idle_stop;
        ctrl_rd[`TAST_B_WBLK]  = q.wr_block;
        ctrl_rd[`TAST_B_WPEND] = async_mode & (q.wstate == tast_pkg::TAST_W_PEND);
        ctrl_rd[`TAST_B_GATE]  = q.gate_en;
        ctrl_rd[`TAST_B_PS_HI:`TAST_B_PS_LO] = q.prescale;
        ctrl_rd[`TAST_B_SYNC]  = q.sync;
        ctrl_rd[`TAST_B_CS]    = q.csrc;
        ctrl_new = tast_alias(ctrl_rd, wdata, op);
        cnt_new  = tast_alias({16'h0000, q.count}, wdata, op);
        per_new  = tast_alias({16'h0000, q.period}, wdata, op);
        stat_new = tast_alias({31'h0000_0000, q.match_flag}, wdata, op);
        src_new  = tast_alias({31'h0000_0000, q.sosc_sel}, wdata, op);
    end

    //------------------------------------------------------------
    // next state
    //------------------------------------------------------------
    always_comb begin
        d = q;
        d.ext_s1  = external_count_input;
        d.ext_s2  = q.ext_s1;
        d.ext_s3  = q.ext_s2;
        d.osc_s1  = low_power_osc;
        d.osc_s2  = q.osc_s1;
        d.osc_s3  = q.osc_s2;
        d.gate_s1 = gate_input;
        d.gate_s2 = q.gate_s1;
        d.match_pulse = wrap;
        if (ctrl_wr) begin
            d.on        = ctrl_new[`TAST_B_ON];
            d.idle_stop = ctrl_new[`TAST_B_IDLE];
            d.wr_block  = ctrl_new[`TAST_B_WBLK];
            d.gate_en   = ctrl_new[`TAST_B_GATE];
            d.prescale  = ctrl_new[`TAST_B_PS_HI:`TAST_B_PS_LO];
            d.sync      = ctrl_new[`TAST_B_SYNC];
            d.csrc      = ctrl_new[`TAST_B_CS];
        end
        if (src_wr) begin
            d.sosc_sel = src_new[`TAST_B_SOSC];
        end
        if (per_wr) begin
            d.period = per_new[15:0];
        end
        if (!q.on) begin
            d.pre_cnt = 8'h00;
        end else if (run && cnt_in) begin
            d.pre_cnt = tick ? 8'h00 : q.pre_cnt + 8'h01;
        end
        // restart on control write: a smaller ratio must not wait out a stale count
        if (ctrl_wr) begin
            d.pre_cnt = 8'h00;
        end
        if (wrap) begin
            d.count = 16'h0000;
        end else if (tick) begin
            d.count = q.count + 16'h0001;
        end
        // a crossing write lands after the last tick of the window
        case (q.wstate)
            tast_pkg::TAST_W_IDLE: begin
                d.pend_cnt = 4'h0;
            end
            tast_pkg::TAST_W_PEND: begin
                d.pend_cnt = q.pend_cnt - 4'h1;
                if (cnt_commit) begin
                    d.count  = q.staged;
                    d.wstate = tast_pkg::TAST_W_IDLE;
                end
            end
            default: begin
                d.wstate = tast_pkg::TAST_W_IDLE;
            end
        endcase
        if (cnt_accept) begin
            d.staged   = cnt_new[15:0];
            d.pend_cnt = XFER_CYC;
            d.wstate   = tast_pkg::TAST_W_PEND;
        end
        if (cnt_direct) begin
            d.count = cnt_new[15:0];
        end
        // the match set wins over a software clear in the same cycle
        if (stat_wr) begin
            d.match_flag = stat_new[`TAST_B_FLAG];
        end
        if (wrap) begin
            d.match_flag = 1'b1;
        end
        d.rdata = 32'h0000_0000;
        if (!rd || addr[3:0] != 4'h0) begin
            d.rdata = 32'h0000_0000;
        end else if (reg_sel == `TAST_OFF_CTRL) begin
            d.rdata = ctrl_rd;
        end else if (reg_sel == `TAST_OFF_COUNT) begin
            d.rdata = {16'h0000, q.count};
        end else if (reg_sel == `TAST_OFF_PERIOD) begin
            d.rdata = {16'h0000, q.period};
        end else if (reg_sel == `TAST_OFF_STATUS) begin
            d.rdata = {31'h0000_0000, q.match_flag};
        end else if (reg_sel == `TAST_OFF_SRC) begin
            d.rdata = {31'h0000_0000, q.sosc_sel};
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            q        <= '0;
            q.period <= `TAST_PERIOD_RST;
        end else begin
            q <= d;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            async_write_pending <= 1'b0;
        end else begin
            async_write_pending <= d.csrc & ~d.sync & (d.wstate == tast_pkg::TAST_W_PEND);
        end
    end

    assign rdata        = q.rdata;
    assign count_value  = q.count;
    assign period_match = q.match_pulse;

    //------------------------------------------------------------
    // checks
    //------------------------------------------------------------
    default clocking tast_cb @(posedge mclk);
    endclocking
    default disable iff (rst);

    logic quiet;
    assign quiet = !cnt_wr && (q.wstate == tast_pkg::TAST_W_IDLE);

    sequence s_accept_blocked;
        cnt_accept && q.wr_block;
    endsequence

    sequence s_crossing;
        (q.wstate == tast_pkg::TAST_W_PEND)[*3] ##1 (q.wstate == tast_pkg::TAST_W_IDLE);
    endsequence

    count_step_a: assert property (tick && !wrap && quiet |=> q.count == $past(q.count) + 16'h0001)
        else $error("count did not step");
    div_eight_a: assert property (tick && q.prescale == 2'h1 |-> q.pre_cnt == 8'h07)
        else $error("prescale 1:8 wrong");
    div_top_a: assert property (tick && q.prescale == 2'h3 |-> q.pre_cnt == 8'hFF)
        else $error("prescale 1:256 wrong");
    enable_stop_a: assert property (!q.on && quiet |=> $stable(q.count))
        else $error("count moved while disabled");
    idle_halt_a: assert property (idle_mode && q.idle_stop |-> !tick)
        else $error("count moved in idle");
    wblock_keep_a: assert property (cnt_wr && q.wr_block && q.wstate == tast_pkg::TAST_W_PEND
                                    |=> $stable(q.staged))
        else $error("blocked write taken");
    pend_window_a: assert property (s_accept_blocked |=> s_crossing)
        else $error("pending window wrong");
    sync_pend_a: assert property (rd && addr == 8'h00 && !async_mode |=> rdata[11] == 1'b0)
        else $error("pending set in sync mode");
    gate_low_a: assert property (!q.csrc && q.gate_en && !q.gate_s2 |-> !tick)
        else $error("counted with gate low");
    sleep_hold_a: assert property (sleep_mode && !async_mode |-> !tick)
        else $error("sync count in sleep");
    alias_set_a: assert property (ctrl_wr && op == `TAST_OP_SET |=> q.on == ($past(q.on) | $past(wdata[15])))
        else $error("set alias wrong");
    osc_edge_a: assert property (tick && q.csrc && q.sosc_sel |-> q.osc_s2 && !q.osc_s3)
        else $error("osc tick without edge");
    ext_edge_a: assert property (q.csrc && !ext_edge |-> !tick)
        else $error("external tick without edge");
    match_wrap_a: assert property (wrap && quiet |=> q.count == 16'h0000 && q.match_flag && period_match)
        else $error("no wrap at period");
    div_one_a: assert property (tick && q.prescale == 2'h0 |-> q.pre_cnt == 8'h00)
        else $error("prescale 1:1 wrong");
    div_sixty_a: assert property (tick && q.prescale == 2'h2 |-> q.pre_cnt == 8'h3F)
        else $error("prescale 1:64 wrong");
    pre_restart_a: assert property (ctrl_wr |=> q.pre_cnt == 8'h00)
        else $error("prescaler kept old count");
    off_clear_a: assert property (!q.on |=> q.pre_cnt == 8'h00)
        else $error("prescaler ran while off");
    off_idle_a: assert property (!q.on |-> !tick)
        else $error("tick while off");
    sync_write_a: assert property (cnt_direct && op == `TAST_OP_WRITE |=> count_value == $past(wdata[15:0]))
        else $error("sync count write lost");
    pend_pin_a: assert property (async_write_pending == ctrl_rd[`TAST_B_WPEND])
        else $error("pending output differs from bit");
    commit_land_a: assert property (cnt_commit && !cnt_direct |=> q.count == $past(q.staged))
        else $error("crossing write not landed");
    staged_take_a: assert property (cnt_accept && op == `TAST_OP_WRITE |=> q.staged == $past(wdata[15:0]))
        else $error("accepted write not staged");
    gate_ext_a: assert property (q.csrc && !q.gate_s2 && run && ext_edge && q.prescale == 2'h0 |-> tick)
        else $error("gate blocked external count");
    gate_high_a: assert property (!q.csrc && q.gate_en && q.gate_s2 && run && q.prescale == 2'h0 |-> tick)
        else $error("no count with gate high");
    clr_alias_a: assert property (ctrl_wr && op == `TAST_OP_CLR |=> q.on == ($past(q.on) & !$past(wdata[15])))
        else $error("clear alias wrong");
    inv_alias_a: assert property (ctrl_wr && op == `TAST_OP_INV |=> q.sync == ($past(q.sync) ^ $past(wdata[2])))
        else $error("invert alias wrong");
    alias_read_a: assert property (rd && addr[3:0] != 4'h0 |=> rdata == 32'h0000_0000)
        else $error("alias read not zero");
    flag_set_a: assert property (wrap |=> q.match_flag)
        else $error("match flag not set");
    src_pick_a: assert property (tick && q.csrc && !q.sosc_sel |-> q.ext_s2 && !q.ext_s3)
        else $error("pin tick without edge");
endmodule // tast_timer

// ---- tast_far_model.sv ----
// far-side model: external count pin, gate pin and secondary oscillator
`timescale 1ns/1ns
module tast_far_model (
    // clock and reset
    input  wire logic   mclk,
    input  wire logic   rst,
    // commands from the bench
    input  wire logic   ext_run,
    input  wire logic   gate_req,
    // pins
    output logic        external_count_input,
    output logic        gate_input,
    output logic        low_power_osc,
    // rising edges sent on the external pin
    output logic [15:0] ext_edges
);
    //----------------------------------------
    // pin generators
    //----------------------------------------
    logic [2:0] ext_div_q;
    logic [2:0] osc_div_q;
    // pin clock stands low between bursts, so no stray edge is counted
    assign external_count_input = ext_div_q[2];
    // oscillator runs free, as a crystal would
    assign low_power_osc = osc_div_q[2];
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            ext_div_q  <= 3'h0;
            osc_div_q  <= 3'h0;
            gate_input <= 1'b0;
            ext_edges  <= 16'h0000;
        end else begin
            ext_div_q  <= ext_run ? ext_div_q + 3'h1 : 3'h0;
            osc_div_q  <= osc_div_q + 3'h1;
            gate_input <= gate_req;
            if (ext_run && ext_div_q == 3'h3) begin
                ext_edges <= ext_edges + 16'h0001;
            end
        end
    end
endmodule // tast_far_model

// ---- tast_tb.sv ----
// self-checking bench of the 16-bit timer
`timescale 1ns/1ns
module testbench;
    //----------------------------------------
    // addresses and signals
    //----------------------------------------
    localparam logic [7:0] A_CTL = 8'h00;
    localparam logic [7:0] A_CNT = 8'h10;
    localparam logic [7:0] A_PER = 8'h20;
    localparam logic [7:0] A_STS = 8'h30;
    localparam logic [7:0] A_SRC = 8'h40;
    logic        mclk, rst, wr, rd, idle_mode, sleep_mode, ext_run, gate_req;
    logic [7:0]  addr;
    logic [31:0] wdata, rdata;
    logic [15:0] count_value, ext_edges, c0, e0;
    logic        period_match, async_write_pending, ext_pin, gate_pin, osc_pin;
    int          bad_count, compares, i, n;
    //----------------------------------------
    // instances
    //----------------------------------------
    tast_timer #(.XFER_CYC(4'h3)) dut (.mclk(mclk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .idle_mode(idle_mode), .sleep_mode(sleep_mode), .external_count_input(ext_pin),
        .gate_input(gate_pin), .low_power_osc(osc_pin), .count_value(count_value),
        .period_match(period_match), .async_write_pending(async_write_pending));
    tast_far_model far (.mclk(mclk), .rst(rst), .ext_run(ext_run), .gate_req(gate_req),
        .external_count_input(ext_pin), .gate_input(gate_pin), .low_power_osc(osc_pin), .ext_edges(ext_edges));
    always #5 mclk = ~mclk;
    //----------------------------------------
    // tasks
    //----------------------------------------
    task automatic complete_run();
        $display("compares %0d mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e, input string what);
        compares++;
        if (g !== e) begin
            bad_count++;
            $display("[ERR] %0t %s got %h expected %h", $time, what, g, e);
        end
    endtask
    task automatic cycles(input int k);
        repeat (k) @(posedge mclk);
        #1;
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge mclk);
        wr <= 1'b0;
        #1;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input string what);
        @(posedge mclk);
        rd <= 1'b1;
        addr <= a;
        @(posedge mclk);
        rd <= 1'b0;
        #1;
        chk(rdata, e, what);
    endtask
    // cycles between two count changes; bounded so a stuck count ends the run
    task automatic gap(output int k);
        for (int j = 0; j < 2; j++) begin
            c0 = count_value;
            k = 0;
            while (count_value === c0 && k < 600) begin
                cycles(1);
                k++;
            end
            if (k >= 600) begin
                bad_count++;
                $display("[ERR] %0t count stuck", $time);
                complete_run();
            end
        end
    endtask
    //----------------------------------------
    // sequence
    //----------------------------------------
    initial begin
        mclk = 1'b0;
        rst = 1'b1;
        {wr, rd, idle_mode, sleep_mode, ext_run, gate_req} = 6'h00;
        addr = 8'h00;
        wdata = 32'h0000_0000;
        bad_count = 0;
        compares = 0;
        repeat (16) @(posedge mclk);
        rst <= 1'b0;
        cycles(1);
        rd_chk(A_CTL, 32'h0000_0000, "ctl reset");
        rd_chk(A_PER, 32'h0000_FFFF, "period reset");
        rd_chk(A_CNT, 32'h0000_0000, "count reset");
        wr_reg(8'h50, 32'hFFFF_FFFF);
        rd_chk(8'h50, 32'h0000_0000, "unmapped");
        $display("test reset done");
        // aliases; upper and read-only bits must not stick
        wr_reg(A_CTL, 32'hFFFF_2834);
        rd_chk(A_CTL, 32'h0000_2034, "ctl write");
        wr_reg(A_CTL + 8'h08, 32'h0000_0080);
        rd_chk(A_CTL, 32'h0000_20B4, "set alias");
        wr_reg(A_CTL + 8'h04, 32'h0000_2000);
        rd_chk(A_CTL, 32'h0000_00B4, "clr alias");
        wr_reg(A_CTL + 8'h0C, 32'h0000_1084);
        rd_chk(A_CTL, 32'h0000_1030, "inv alias");
        rd_chk(A_CTL + 8'h08, 32'h0000_0000, "alias read");
        $display("test alias done");
        // sync write lands next cycle, no pending; stopped count holds
        wr_reg(A_CTL, 32'h0000_0000);
        wr_reg(A_CNT, 32'h0000_0055);
        chk({31'h0, async_write_pending}, 32'h0, "sync pending");
        chk({16'h0, count_value}, 32'h55, "sync write");
        cycles(10);
        chk({16'h0, count_value}, 32'h55, "stopped");
        // wrap at period
        wr_reg(A_CNT, 32'h0000_0000);
        wr_reg(A_PER, 32'h0000_0002);
        wr_reg(A_CTL, 32'h0000_8000);
        n = 0;
        while (period_match !== 1'b1 && n < 20) begin
            cycles(1);
            n++;
        end
        if (n >= 20) begin
            bad_count++;
            $display("[ERR] %0t no match pulse", $time);
            complete_run();
        end
        chk({31'h0, period_match}, 32'h1, "match pulse");
        c0 = count_value;
        for (i = 0; i < 6; i++) begin
            cycles(1);
            chk({16'h0, count_value}, (c0 == 16'h2) ? 32'h0 : 32'(c0) + 32'h1, "wrap seq");
            c0 = count_value;
        end
        wr_reg(A_CTL, 32'h0000_0000);
        cycles(1);
        rd_chk(A_STS, 32'h0000_0001, "flag set");
        wr_reg(A_STS + 8'h04, 32'h0000_0001);
        rd_chk(A_STS, 32'h0000_0000, "flag clr");
        wr_reg(A_PER, 32'h0000_FFFF);
        $display("test wrap done");
        // prescaler codes
        for (i = 0; i < 4; i++) begin
            wr_reg(A_CTL, 32'h0000_8000 | (32'(i) << 4));
            gap(n);
            chk(32'(n), (i == 0) ? 32'h1 : (i == 1) ? 32'h8 : (i == 2) ? 32'h40 : 32'h100, "prescale");
        end
        $display("test prescale done");
        // gated internal count
        wr_reg(A_CTL, 32'h0000_8080);
        cycles(4);
        c0 = count_value;
        cycles(20);
        chk({16'h0, count_value}, {16'h0, c0}, "gate low");
        gate_req <= 1'b1;
        cycles(20);
        chk({31'h0, count_value !== c0}, 32'h1, "gate high");
        gate_req <= 1'b0;
        // external sync source, gate bit set but ignored
        wr_reg(A_CTL, 32'h0000_0000);
        cycles(1);
        wr_reg(A_CNT, 32'h0000_0000);
        wr_reg(A_CTL, 32'h0000_8086);
        e0 = ext_edges;
        ext_run <= 1'b1;
        cycles(100);
        ext_run <= 1'b0;
        cycles(10);
        chk({16'h0, count_value}, {16'h0, ext_edges - e0}, "ext count");
        $display("test gate done");
        // idle and sleep
        wr_reg(A_CTL, 32'h0000_A000);
        idle_mode <= 1'b1;
        cycles(2);
        c0 = count_value;
        cycles(20);
        chk({16'h0, count_value}, {16'h0, c0}, "idle stop");
        wr_reg(A_CTL + 8'h04, 32'h0000_2000);
        cycles(5);
        chk({31'h0, count_value !== c0}, 32'h1, "idle run");
        idle_mode <= 1'b0;
        sleep_mode <= 1'b1;
        cycles(2);
        c0 = count_value;
        cycles(20);
        chk({16'h0, count_value}, {16'h0, c0}, "sleep stop");
        wr_reg(A_CTL, 32'h0000_8002);
        ext_run <= 1'b1;
        cycles(40);
        ext_run <= 1'b0;
        cycles(10);
        chk({31'h0, count_value !== c0}, 32'h1, "sleep async");
        sleep_mode <= 1'b0;
        $display("test power done");
        // async count write window, with and without the block bit
        wr_reg(A_CNT, 32'h0000_1234);
        chk({31'h0, async_write_pending}, 32'h1, "pend c1");
        cycles(2);
        chk({31'h0, async_write_pending}, 32'h1, "pend c3");
        cycles(1);
        chk({31'h0, async_write_pending}, 32'h0, "pend c4");
        chk({16'h0, count_value}, 32'h1234, "async write");
        rd_chk(A_CTL, 32'h0000_8002, "pend bit clr");
        for (i = 0; i < 2; i++) begin
            wr_reg(A_CTL, (i == 0) ? 32'h0000_9002 : 32'h0000_8002);
            wr_reg(A_CNT, 32'h0000_1111);
            wr_reg(A_CNT, 32'h0000_2222);
            cycles(8);
            chk({16'h0, count_value}, (i == 0) ? 32'h1111 : 32'h2222, "write block");
        end
        $display("test async done");
        // secondary oscillator as source, pin clock idle
        wr_reg(A_SRC, 32'h0000_0001);
        rd_chk(A_SRC, 32'h0000_0001, "src cfg");
        wr_reg(A_CNT, 32'h0000_0000);
        cycles(6);
        cycles(80);
        chk({31'h0, count_value >= 16'h8 && count_value <= 16'hB}, 32'h1, "osc count");
        $display("test osc done");
        complete_run();
    end
endmodule // testbench
